// file: src/servo_tune_pkg.sv
// Constants for servo loop tuning and P/PI mode switch logic
package servo_tune_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_GAIN_LEVEL = 8'h00;
  localparam logic [7:0] OFS_SPEED_GAIN = 8'h04;
  localparam logic [7:0] OFS_FUNC_SEL = 8'h08;
  localparam logic [7:0] OFS_FF_GAIN = 8'h0c;
  localparam logic [7:0] OFS_FF_TC = 8'h10;
  localparam logic [7:0] OFS_MODE_SEL = 8'h14;
  localparam logic [7:0] OFS_THR_FORCE = 8'h18;
  localparam logic [7:0] OFS_THR_SPEED = 8'h1c;
  localparam logic [7:0] OFS_THR_ACCEL = 8'h20;
  localparam logic [7:0] OFS_THR_POSERR = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_CUR_GAIN = 8'h2c;
  localparam logic [7:0] OFS_RESTART = 8'h30;
  // Limits and reset values
  localparam logic [15:0] GAIN_LEVEL_MIN = 16'h0064;
  localparam logic [15:0] GAIN_LEVEL_MAX = 16'h07d0;
  localparam logic [15:0] GAIN_LEVEL_RST = 16'h07d0;
  localparam logic [15:0] SPEED_GAIN_RST = 16'h0190;
  localparam logic [15:0] FF_GAIN_MAX = 16'h0064;
  localparam logic [15:0] FF_TC_MAX = 16'h1900;
  localparam logic [15:0] THR_FORCE_MAX = 16'h0320;
  localparam logic [15:0] THR_FORCE_RST = 16'h00c8;
  localparam logic [15:0] THR_SPEED_MAX = 16'h2710;
  localparam logic [15:0] THR_ACCEL_MAX = 16'h7530;
  localparam logic [15:0] THR_POSERR_MAX = 16'h2710;
  localparam logic [15:0] FUNC_SEL_RST = 16'h0000;
  // Third digit of function select: speed detection method
  localparam int DET_DIGIT_LSB = 8;
  localparam logic [3:0] MODE_SEL_MAX = 4'h4;
  // Filter coefficient shift and time unit per update tick
  localparam int FILT_FRAC = 16;
  localparam int TICK_SCALE = 1;
  typedef enum logic [2:0] {
    SW_FORCE, SW_SPEED, SW_ACCEL, SW_POSERR, SW_OFF
  } sw_cond_e;
endpackage : servo_tune_pkg

// file: src/ff_lag_filter.sv
// First-order lag filter for the position feedforward term
`timescale 1ns/10ps
`default_nettype none
module ff_lag_filter (
  input wire logic CLK,
  input wire logic RST,
  input wire logic tick,
  input wire logic signed [31:0] din,
  input wire logic [15:0] tc,
  output logic signed [31:0] dout
);
  import servo_tune_pkg::*;
  typedef struct packed {
    logic signed [31:0] acc;
  } filt_s;
  filt_s st;
  filt_s next_st;
  logic signed [33:0] diff;
  logic signed [33:0] step;
  always_comb begin
    next_st = st;
    diff = 34'(din) - 34'(st.acc);
    // Divide by (tc+1) ticks; tc of zero passes through
    step = diff / $signed({18'h0, tc + 16'h0001});
    if (tick) begin
      if (tc == 16'h0000) begin
        next_st.acc = din;
      end else begin
        next_st.acc = st.acc + 32'(step);
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.acc;
endmodule : ff_lag_filter
`default_nettype wire

// file: src/servo_loop_tune.sv
// Servo loop tuning registers, feedforward path and P/PI mode switch
// Function
// - Current gain level 100..2000 percent, default 2000 means reduction off
// - Current gain scales from speed loop gain, applied immediately
// - Function select third digit picks speed detection, used after restart
// - Feedforward gain 0..100 percent, default 0, immediate
// - Feedforward lag filter time constant 0..6400, default 0, immediate
// - Speed loop switches P versus PI by selected condition
// - Selector 0 force, 1 speed, 2 accel, 3 poserr, 4 off
// - Force condition: P while force reference above threshold
// - Speed condition: P while speed reference above threshold
// - Accel condition: P while acceleration above threshold
// - Poserr condition: P while position error above threshold
// - Poserr condition acts only in position control
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module servo_loop_tune (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LOOP_TICK,
  input wire logic POS_CTRL,
  input wire logic signed [31:0] FORCE_REF,
  input wire logic signed [31:0] SPEED_REF,
  input wire logic signed [31:0] ACCEL_REF,
  input wire logic signed [31:0] POS_ERR,
  input wire logic signed [31:0] FF_IN,
  output logic P_ONLY,
  output logic [31:0] CUR_GAIN,
  output logic SPEED_DET2,
  output logic signed [31:0] FF_OUT
);
  import servo_tune_pkg::*;

  typedef struct packed {
    logic [15:0] current_gain_level;
    logic [15:0] speed_loop_gain;
    logic [15:0] function_select_misc;
    logic [15:0] feedforward_gain;
    logic [15:0] feedforward_filter_tc;
    logic [3:0] mode_switch_select;
    logic [15:0] mode_switch_force_threshold;
    logic [15:0] mode_switch_speed_threshold;
    logic [15:0] mode_switch_accel_threshold;
    logic [15:0] mode_switch_poserr_threshold;
    logic det2;
    logic p_only;
    logic [31:0] cur_gain;
    logic signed [31:0] ff_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s st;
  state_s next_st;
  logic wr_phase;
  logic rd_phase;
  logic wr_bad;
  logic signed [31:0] ff_filt;
  logic signed [47:0] ff_prod;
  sw_cond_e cond;
  logic over;

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  function automatic logic in_range(input logic [31:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v <= {16'h0000, hi}) && (v >= {16'h0000, lo});
  endfunction : in_range

  function automatic sw_cond_e decode_sel(input logic [3:0] s);
    case (s)
      4'h0: decode_sel = SW_FORCE;
      4'h1: decode_sel = SW_SPEED;
      4'h2: decode_sel = SW_ACCEL;
      4'h3: decode_sel = SW_POSERR;
      default: decode_sel = SW_OFF;
    endcase
  endfunction : decode_sel

  ff_lag_filter u_filt (
    .CLK(CLK),
    .RST(RST),
    .tick(LOOP_TICK),
    .din(FF_IN),
    .tc(st.feedforward_filter_tc),
    .dout(ff_filt)
  );

  assign wr_phase = PSEL && PENABLE && PWRITE && !st.pready;
  assign rd_phase = PSEL && PENABLE && !PWRITE && !st.pready;
  assign cond = decode_sel(st.mode_switch_select);
  assign ff_prod = 48'(ff_filt) * $signed({32'h0, st.feedforward_gain});

  always_comb begin
    next_st = st;
    wr_bad = 1'b0;
    next_st.pready = PSEL && PENABLE && !st.pready;
    next_st.pslverr = 1'b0;
    if (wr_phase) begin
      if (PADDR == OFS_GAIN_LEVEL) begin
        if (in_range(PWDATA, GAIN_LEVEL_MIN, GAIN_LEVEL_MAX)) begin
          next_st.current_gain_level = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_SPEED_GAIN) begin
        next_st.speed_loop_gain = PWDATA[15:0];
      end else if (PADDR == OFS_FUNC_SEL) begin
        next_st.function_select_misc = PWDATA[15:0];
      end else if (PADDR == OFS_FF_GAIN) begin
        if (in_range(PWDATA, 16'h0000, FF_GAIN_MAX)) begin
          next_st.feedforward_gain = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_FF_TC) begin
        if (in_range(PWDATA, 16'h0000, FF_TC_MAX)) begin
          next_st.feedforward_filter_tc = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_MODE_SEL) begin
        if (PWDATA <= 32'(MODE_SEL_MAX)) begin
          next_st.mode_switch_select = PWDATA[3:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_THR_FORCE) begin
        if (in_range(PWDATA, 16'h0000, THR_FORCE_MAX)) begin
          next_st.mode_switch_force_threshold = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_THR_SPEED) begin
        if (in_range(PWDATA, 16'h0000, THR_SPEED_MAX)) begin
          next_st.mode_switch_speed_threshold = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_THR_ACCEL) begin
        if (in_range(PWDATA, 16'h0000, THR_ACCEL_MAX)) begin
          next_st.mode_switch_accel_threshold = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_THR_POSERR) begin
        if (in_range(PWDATA, 16'h0000, THR_POSERR_MAX)) begin
          next_st.mode_switch_poserr_threshold = PWDATA[15:0];
        end else begin
          wr_bad = 1'b1;
        end
      end else if (PADDR == OFS_RESTART) begin
        // detection method latched only on restart
        next_st.det2 = st.function_select_misc[DET_DIGIT_LSB];
      end else begin
        wr_bad = 1'b1;
      end
      next_st.pslverr = wr_bad;
    end
    if (rd_phase) begin
      next_st.prdata = 32'h0000_0000;
      if (PADDR == OFS_GAIN_LEVEL) begin
        next_st.prdata = {16'h0000, st.current_gain_level};
      end else if (PADDR == OFS_SPEED_GAIN) begin
        next_st.prdata = {16'h0000, st.speed_loop_gain};
      end else if (PADDR == OFS_FUNC_SEL) begin
        next_st.prdata = {16'h0000, st.function_select_misc};
      end else if (PADDR == OFS_FF_GAIN) begin
        next_st.prdata = {16'h0000, st.feedforward_gain};
      end else if (PADDR == OFS_FF_TC) begin
        next_st.prdata = {16'h0000, st.feedforward_filter_tc};
      end else if (PADDR == OFS_MODE_SEL) begin
        next_st.prdata = {28'h0000000, st.mode_switch_select};
      end else if (PADDR == OFS_THR_FORCE) begin
        next_st.prdata = {16'h0000, st.mode_switch_force_threshold};
      end else if (PADDR == OFS_THR_SPEED) begin
        next_st.prdata = {16'h0000, st.mode_switch_speed_threshold};
      end else if (PADDR == OFS_THR_ACCEL) begin
        next_st.prdata = {16'h0000, st.mode_switch_accel_threshold};
      end else if (PADDR == OFS_THR_POSERR) begin
        next_st.prdata = {16'h0000, st.mode_switch_poserr_threshold};
      end else if (PADDR == OFS_STATUS) begin
        next_st.prdata = {30'h00000000, st.det2, st.p_only};
      end else if (PADDR == OFS_CUR_GAIN) begin
        next_st.prdata = st.cur_gain;
      end else if (PADDR == OFS_RESTART) begin
        next_st.prdata = 32'h0000_0000;
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    // current gain = speed gain * level percent, immediate
    next_st.cur_gain = 32'(st.speed_loop_gain) * 32'(st.current_gain_level);
    next_st.ff_out = 32'(ff_prod / 48'sd100);
    case (cond)
      SW_FORCE: over = mag(FORCE_REF) >
        {16'h0000, st.mode_switch_force_threshold};
      SW_SPEED: over = mag(SPEED_REF) >
        {16'h0000, st.mode_switch_speed_threshold};
      SW_ACCEL: over = mag(ACCEL_REF) >
        {16'h0000, st.mode_switch_accel_threshold};
      SW_POSERR: over = POS_CTRL && (mag(POS_ERR) >
        {16'h0000, st.mode_switch_poserr_threshold});
      default: over = 1'b0;
    endcase
    // mode switch updated on loop tick
    if (LOOP_TICK) begin
      next_st.p_only = over;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
      st.current_gain_level <= GAIN_LEVEL_RST;
      st.speed_loop_gain <= SPEED_GAIN_RST;
      st.function_select_misc <= FUNC_SEL_RST;
      st.mode_switch_force_threshold <= THR_FORCE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign P_ONLY = st.p_only;
  assign CUR_GAIN = st.cur_gain;
  assign SPEED_DET2 = st.det2;
  assign FF_OUT = st.ff_out;

  mode_follow_a: assert property (@(posedge CLK) disable iff (RST)
    LOOP_TICK |=> P_ONLY == $past(over)) else $error("mode switch lag");
  poserr_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (cond == SW_POSERR && !POS_CTRL && LOOP_TICK) |=> !P_ONLY)
    else $error("poserr outside position control");
  sel_off_a: assert property (@(posedge CLK) disable iff (RST)
    (cond == SW_OFF && LOOP_TICK) |=> !P_ONLY) else $error("off gave P");
  gain_range_a: assert property (@(posedge CLK) disable iff (RST)
    st.current_gain_level >= GAIN_LEVEL_MIN &&
    st.current_gain_level <= GAIN_LEVEL_MAX) else $error("gain range");
  ff_range_a: assert property (@(posedge CLK) disable iff (RST)
    st.feedforward_gain <= FF_GAIN_MAX) else $error("ff gain range");
  tc_range_a: assert property (@(posedge CLK) disable iff (RST)
    st.feedforward_filter_tc <= FF_TC_MAX) else $error("tc range");
  det_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(wr_phase && PADDR == OFS_RESTART) |=> $stable(SPEED_DET2))
    else $error("detection changed early");
  // current gain tracks within one cycle
  // Sampled reset keeps the release edge out; product uses last cycle's terms
  cur_gain_a: assert property (@(posedge CLK) disable iff (RST)
    !RST && $stable(st.speed_loop_gain) && $stable(st.current_gain_level)
    |=> CUR_GAIN == 32'($past(st.speed_loop_gain)) *
    32'($past(st.current_gain_level))) else $error("current gain stale");
  apb_one_a: assert property (@(posedge CLK) disable iff (RST)
    PREADY |=> !PREADY) else $error("pready long");

  p_mode_c: cover property (@(posedge CLK) disable iff (RST)
    !P_ONLY ##1 P_ONLY);
  poserr_c: cover property (@(posedge CLK) disable iff (RST)
    cond == SW_POSERR && P_ONLY);
  det_c: cover property (@(posedge CLK) disable iff (RST) SPEED_DET2);
  err_c: cover property (@(posedge CLK) disable iff (RST) PSLVERR);
endmodule : servo_loop_tune
`default_nettype wire

// file: bench/motor_side.sv
// Motor and loop-timing model that feeds the mode switch inputs
`timescale 1ns/10ps
`default_nettype none
module motor_side (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] pick,
  input wire logic signed [31:0] level,
  input wire logic pos_mode,
  output logic LOOP_TICK,
  output logic POS_CTRL,
  output logic signed [31:0] FORCE_REF,
  output logic signed [31:0] SPEED_REF,
  output logic signed [31:0] ACCEL_REF,
  output logic signed [31:0] POS_ERR
);
  // Unpicked quantities sit far above any threshold to expose a wrong mux
  localparam logic signed [31:0] BIG = 32'sd40000;
  logic [1:0] phase;
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
    LOOP_TICK <= !RST && phase == 2'h3;
    POS_CTRL <= pos_mode;
    FORCE_REF <= (pick == 2'h0) ? level : BIG;
    SPEED_REF <= (pick == 2'h1) ? level : BIG;
    ACCEL_REF <= (pick == 2'h2) ? level : BIG;
    POS_ERR <= (pick == 2'h3) ? level : BIG;
  end
endmodule : motor_side
`default_nettype wire

// file: bench/tb_servo_loop_pi_mode_switch.sv
// Register and mode switch test sequence for the servo tuning block
`timescale 1ns/10ps
`default_nettype none
module tb_servo_loop_pi_mode_switch;
  import servo_tune_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pos_mode = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cur_gain, rdv;
  logic pready, pslverr, tick, pos_ctrl, p_only, det2, e;
  logic [1:0] pick = 2'h0;
  logic signed [31:0] level = 0, ff_in = 0, fr, sr, ar, pe, ff_out;
  int err_count = 0, compares = 0;
  logic [7:0] ofs[10] = '{OFS_GAIN_LEVEL, OFS_SPEED_GAIN, OFS_FUNC_SEL,
    OFS_FF_GAIN, OFS_FF_TC, OFS_MODE_SEL, OFS_THR_FORCE, OFS_THR_SPEED,
    OFS_THR_ACCEL, OFS_THR_POSERR};
  logic [31:0] rv[10] = '{2000, 400, 0, 0, 0, 0, 200, 0, 0, 0};
  logic [31:0] hi[10] = '{2000, 0, 0, 100, 6400, 4, 800, 10000, 30000, 10000};

  initial begin
    forever #50 clk = ~clk;
  end

  servo_loop_tune uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LOOP_TICK(tick),
    .POS_CTRL(pos_ctrl), .FORCE_REF(fr), .SPEED_REF(sr), .ACCEL_REF(ar),
    .POS_ERR(pe), .FF_IN(ff_in), .P_ONLY(p_only), .CUR_GAIN(cur_gain),
    .SPEED_DET2(det2), .FF_OUT(ff_out));
  motor_side far (.CLK(clk), .RST(rst), .pick(pick), .level(level),
    .pos_mode(pos_mode), .LOOP_TICK(tick), .POS_CTRL(pos_ctrl),
    .FORCE_REF(fr), .SPEED_REF(sr), .ACCEL_REF(ar), .POS_ERR(pe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Setup, access, then hold until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // The wait ends once pready is sampled high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ee);
    apb(1, a, d);
    chk(e, ee);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic ee);
    apb(0, a, 0);
    chk(rdv, x);
    chk(e, ee);
  endtask : rd

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // Whole sequence needs about 440 cycles
  initial begin
    #(100 * 20000);
    err_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 10; i++) rd(ofs[i], rv[i], 0);
    chk(cur_gain, 32'd800000);
    rd(8'h3c, 0, 1);
    wr(OFS_STATUS, 0, 1);
    for (int i = 0; i < 10; i++) begin
      if (i != 1 && i != 2) begin
        wr(ofs[i], hi[i], 0);
        wr(ofs[i], hi[i] + 1, 1);
        rd(ofs[i], hi[i], 0);
      end
    end
    wr(OFS_GAIN_LEVEL, 99, 1);
    wr(OFS_GAIN_LEVEL, 100, 0);
    repeat (3) @(posedge clk);
    chk(cur_gain, 32'd40000);
    wr(OFS_SPEED_GAIN, 100, 0);
    rd(OFS_CUR_GAIN, 32'd10000, 0);
    wr(OFS_FUNC_SEL, 32'h0100, 0);
    repeat (3) @(posedge clk);
    chk(det2, 0);
    wr(OFS_RESTART, 0, 0);
    repeat (3) @(posedge clk);
    chk(det2, 1);
    rd(OFS_STATUS, 32'h0000_0002, 0);
    for (int i = 6; i < 10; i++) wr(ofs[i], 300, 0);
    for (int m = 0; m < 5; m++) begin
      wr(OFS_MODE_SEL, m, 0);
      pick <= m[1:0];
      for (int k = 0; k < 3; k++) begin
        level <= (k == 0) ? 301 : (k == 1) ? 300 : -301;
        repeat (10) @(posedge clk);
        chk(p_only, (m < 4) && k != 1);
      end
    end
    // position error ignored outside position control
    wr(OFS_MODE_SEL, 3, 0);
    pos_mode <= 0;
    level <= 301;
    repeat (10) @(posedge clk);
    chk(p_only, 0);
    pos_mode <= 1;
    // host keeps gain under 80 percent
    wr(OFS_FF_GAIN, 50, 0);
    wr(OFS_FF_TC, 0, 0);
    ff_in <= 0;
    repeat (10) @(posedge clk);
    wr(OFS_FF_TC, 1, 0);
    // Step aligned to a tick so exactly one filter step lands
    @(posedge clk iff tick);
    ff_in <= 1000;
    repeat (6) @(posedge clk);
    chk(ff_out, 32'd250);
    wr(OFS_FF_TC, 0, 0);
    repeat (10) @(posedge clk);
    chk(ff_out, 32'd500);
    conclude();
  end
endmodule : tb_servo_loop_pi_mode_switch
`default_nettype wire
